// >>> dv/rtk_core_asserts.sv
`timescale 1ns/1ps
module rtk_core_asserts #(
  parameter longint REC_CYC = 20
) (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [rtk_pkg::ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [3:0] pstrb, // strobes
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic crystalInPin, // time base
  input wire logic primaryPowerOk, // supply good
  input wire logic irqOut, // request data
  input wire logic irqOe // request enable
);
  import rtk_pkg::*;
  logic rdFlags;
  logic wrB;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // accesses that may release the request pin
  assign rdFlags = psel && penable && !pwrite && paddr[8:2] == IDX_FLAGS;
  assign wrB = psel && penable && pwrite && paddr[8:2] == IDX_CTL_B;
  property p_rdy;
    pready == (psel && penable);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not tied to access phase");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_od;
    irqOut == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("request pin driven high");
  property p_hi;
    prdata[31:8] == 24'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_pwr;
    psel && penable && !primaryPowerOk && $past(primaryPowerOk, 4) == 1'b0 |-> pslverr;
  endproperty
  a_pwr: assert property (p_pwr) else $error("access taken without power");
  property p_map;
    psel && penable && (paddr[11:9] != 3'h0 || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_map: assert property (p_map) else $error("unmapped address accepted");
  property p_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_fall;
    $fell(irqOe) |-> $past(rdFlags) || $past(wrB);
  endproperty
  a_fall: assert property (p_fall) else $error("request dropped without cause");
endmodule

bind rtk_core rtk_core_asserts #(.REC_CYC(REC_CYC)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystalInPin(crystalInPin),
  .primaryPowerOk(primaryPowerOk), .irqOut(irqOut), .irqOe(irqOe));

// >>> dv/rtk_osc_model.sv
`timescale 1ns/1ps
module rtk_osc_model (
  input wire logic clk_sys, // bench clock
  output logic base // time base into the core
);
  initial base = 1'b0;
  // scaled base, one rising edge per two clocks
  always @(posedge clk_sys)
    base <= ~base;
endmodule

// >>> dv/rtk_timekeeping_alarm_core_tb_top.sv
`timescale 1ns/1ps
module rtk_timekeeping_alarm_core_tb_top;
  import rtk_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h1;
  logic pwrOk = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irqOut, irqOe, base;
  logic [7:0] rd;
  logic er;
  logic [7:0] setV [10] = '{8'h59, 8'hC0, 8'h59, 8'hC0, 8'h23, 8'hC0, 8'h07, 8'h29, 8'h02, 8'h04};
  logic [7:0] expV [10] = '{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h03, 8'h04};
  logic [7:0] binV [10] = '{8'h3B, 8'h00, 8'h3B, 8'h00, 8'h8B, 8'h0C, 8'h07, 8'h1F, 8'h0C, 8'h63};
  logic [7:0] binE [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h0C, 8'h01, 8'h01, 8'h01, 8'h00};
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // clock
  always #4 clk_sys = ~clk_sys;
  rtk_osc_model u_osc (.clk_sys(clk_sys), .base(base));
  rtk_core #(.REC_CYC(20)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystalInPin(base), .primaryPowerOk(pwrOk), .irqOut(irqOut), .irqOe(irqOe));
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer on word index i
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_power_on;
    apb(1'b0, 10'h0, 8'h0);
    chk({7'h0, er}, 8'h01);
    pwrOk <= 1'b1;
    repeat (6) @(posedge clk_sys);
    apb(1'b0, 10'(IDX_CTL_A), 8'h0);
    chk({7'h0, er}, 8'h00);
    chk(rd, 8'h20);
  endtask
  task automatic t_map;
    apb(1'b1, 10'(IDX_RAM_LO), 8'hA5);
    apb(1'b1, 10'h07F, 8'h5A);
    apb(1'b0, 10'(IDX_RAM_LO), 8'h0);
    chk(rd, 8'hA5);
    apb(1'b0, 10'h07F, 8'h0);
    chk(rd, 8'h5A);
    apb(1'b0, 10'(IDX_VALID), 8'h0);
    chk(rd, VALID_VAL);
    apb(1'b0, 10'h080, 8'h0);
    chk({7'h0, er}, 8'h01);
  endtask
  task automatic t_set;
    apb(1'b1, 10'(IDX_CTL_B), 8'hA2);
    for (int i = 0; i < 10; i++)
      apb(1'b1, 10'(i), setV[i]);
    apb(1'b1, 10'(IDX_CTL_B), 8'h22);
    apb(1'b0, 10'(IDX_SEC), 8'h0);
    chk(rd, 8'h59);
  endtask
  task automatic t_recover;
    pwrOk <= 1'b0;
    repeat (8) @(posedge clk_sys);
    apb(1'b0, 10'(IDX_SEC), 8'h0);
    chk({7'h0, er}, 8'h01);
    pwrOk <= 1'b1;
    repeat (6) @(posedge clk_sys);
    apb(1'b0, 10'(IDX_SEC), 8'h0);
    chk({7'h0, er}, 8'h01);
    repeat (40) @(posedge clk_sys);
    apb(1'b0, 10'(IDX_SEC), 8'h0);
    chk({7'h0, er}, 8'h00);
  endtask
  task automatic t_tick;
    while (irqOe !== 1'b1)
      @(posedge clk_sys);
    apb(1'b0, 10'(IDX_FLAGS), 8'h0);
    chk(rd, 8'hB0);
    chk({7'h0, irqOe}, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, 10'(i), 8'h0);
      chk(rd, expV[i]);
    end
  endtask
  // binary 12h year end, chain restarted through hold
  task automatic t_format;
    int n;
    n = 0;
    apb(1'b1, 10'(IDX_CTL_B), 8'h84);
    for (int i = 0; i < 10; i++)
      apb(1'b1, 10'(i), binV[i]);
    apb(1'b1, 10'(IDX_CTL_A), 8'h60);
    apb(1'b1, 10'(IDX_CTL_A), 8'h20);
    apb(1'b1, 10'(IDX_CTL_B), 8'h24);
    while (irqOe !== 1'b1)
    begin
      n++;
      @(posedge clk_sys);
    end
    chk({7'h0, (n > 32700) && (n < 32800)}, 8'h01);
    apb(1'b0, 10'(IDX_FLAGS), 8'h0);
    chk(rd, 8'hB0);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, 10'(i), 8'h0);
      chk(rd, binE[i]);
    end
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_power_on();
    t_map();
    t_set();
    t_recover();
    t_tick();
    t_format();
    stop_test();
  end
endmodule

// >>> verilog/rtk_core.sv
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - day of week counts 1..7 at midnight
// - month end rollover with leap February
// - freeze bit stops all counter updates
// - updates resume in selected data format
// - hours bit 7 is PM in 12h
// - bytes accessible any time power allows, no update lockout
// - each second advance, then compare alarm
// - exact alarm fires daily when enabled
// - alarm byte C0..FF matches every value
// - don't-care alarms give hourly/minute/second alarms
// - counting continues whatever primary power does
// - running power-up refuses access for delay
// - stopped oscillator enabled, access immediate
// - oscillator follows control register enable
// - 14 registers plus 114 RAM bytes
// - three maskable sources share one request
// - time base is 32.768kHz input
// - divider 010 runs, 11x holds, 500ms
// - freeze write blocks update, clears pending
module rtk_core #(
  parameter longint REC_CYC = rtk_pkg::REC_DELAY_CYC
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [rtk_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic crystalInPin, // 32.768kHz time base
  input wire logic primaryPowerOk, // supply above trip point
  output logic irqOut, // open-drain request level
  output logic irqOe // drives request pin low
);
  import rtk_pkg::*;

  rtk_time_t tm_r;
  logic [7:0] ram_r [IDX_RAM_LO:BYTE_CNT-1];
  logic [2:0] div_r;
  logic [3:0] rate_r;
  logic [7:0] ctlB_r;
  logic perFlag_r, almFlag_r, updFlag_r;
  logic [14:0] divCnt_r;
  logic xtalS1_r, xtalS2_r, xtalPrev_r;
  logic pwrS1_r, pwrS2_r, pwrPrev_r;
  rtk_pwr_t pwr_r;
  logic [31:0] recCnt_r;
  logic oscSet, xtalTick, secTick, doUpdate, perTick;
  logic running, holding, oscOn, access;
  logic apbSetup, apbDone, mapped, wrEn, rdClr;
  logic [6:0] idx;
  logic [7:0] rdByte, flagsByte, ctlAByte, pendFlag;
  logic [79:0] tmBits;
  logic [79:0] tmWr;
  rtk_time_t tmNxt;
  logic almHit;

  // byte code to binary value
  function automatic logic [7:0] toBin(input logic [7:0] v, input logic bin);
    toBin = bin ? v : 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]});
  endfunction

  // binary value to byte code
  function automatic logic [7:0] toFmt(input logic [7:0] v, input logic bin);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = v / 8'd10;
    ones = v % 8'd10;
    toFmt = bin ? v : {tens[3:0], ones[3:0]};
  endfunction

  // alarm byte of the form 11xxxxxx matches anything
  function automatic logic almMatch(input logic [7:0] alm, input logic [7:0] cur);
    almMatch = (alm[7:6] == 2'b11) || (alm == cur);
  endfunction

  // divider control decode
  // 11x keeps the oscillator on with the chain held
  assign running = (div_r == DIV_RUN);
  assign holding = (div_r[2:1] == DIV_HOLD_HI);
  assign oscOn = running || holding;

  // crystal input and supply level synchronisers
  // only the second and third stages feed logic, the first may be metastable
  always_ff @(posedge clk_sys)
  begin
    xtalS1_r <= crystalInPin;
    xtalS2_r <= xtalS1_r;
    xtalPrev_r <= xtalS2_r;
    pwrS1_r <= primaryPowerOk;
    pwrS2_r <= pwrS1_r;
    pwrPrev_r <= pwrS2_r;
  end

  assign xtalTick = xtalS2_r && !xtalPrev_r && oscOn;
  assign secTick = xtalTick && running && (divCnt_r == SEC_LAST);
  assign doUpdate = secTick && !ctlB_r[B_FREEZE];
  // pending covers the last base ticks before an update
  // freeze clears pending
  assign pendFlag = {7'h00, running && !ctlB_r[B_FREEZE] && (divCnt_r >= SEC_LAST - 15'(PEND_TICKS - 1))};
  // periodic tap: every 2^(rate-1) base ticks
  assign perTick = xtalTick && running && (rate_r != 4'h0)
    && ((divCnt_r & ((15'h0001 << (rate_r - 4'h1)) - 15'h0001)) == 15'h0000);

  // countdown chain
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      divCnt_r <= 15'h0000;
    else if (wrEn && idx == IDX_CTL_A && pwdata[6:4] == DIV_RUN && !running)
      divCnt_r <= HALF_SEC;
    else if (oscSet)
      divCnt_r <= HALF_SEC;
    else if (!running)
      divCnt_r <= 15'h0000;
    else if (xtalTick)
      divCnt_r <= divCnt_r + 15'h0001;
  end

  // next time and calendar value, all arithmetic in binary
  always_comb
  begin
    logic bin;
    logic [7:0] s, m, h, h12, dt, mo, yr, dmax;
    logic pm, cs, cm, ch, cd, cmo;
    bin = ctlB_r[B_FMT];
    h = 8'd0;
    dt = 8'd0;
    mo = 8'd0;
    yr = 8'd0;
    dmax = 8'd31;
    cs = 1'b0;
    cm = 1'b0;
    ch = 1'b0;
    cd = 1'b0;
    cmo = 1'b0;
    tmNxt = tm_r;
    s = toBin(tm_r.sec, bin) + 8'd1;
    m = toBin(tm_r.min, bin);
    h12 = toBin({1'b0, tm_r.hr[6:0]}, bin);
    pm = tm_r.hr[7];
    if (ctlB_r[B_H24])
      h = toBin(tm_r.hr, bin);
    else if (h12 == 8'd12)
      h = pm ? 8'd12 : 8'd0;
    else
      h = pm ? h12 + 8'd12 : h12;
    dt = toBin(tm_r.date, bin);
    mo = toBin(tm_r.mon, bin);
    yr = toBin(tm_r.year, bin);
    case (mo)
      8'd4, 8'd6, 8'd9, 8'd11: dmax = 8'd30;
      8'd2: dmax = (yr[1:0] == 2'b00) ? 8'd29 : 8'd28;
      default: dmax = 8'd31;
    endcase
    cs = (s >= 8'd60);
    cm = cs && (m >= 8'd59);
    ch = cm && (h >= 8'd23);
    cd = ch && (dt >= dmax);
    cmo = cd && (mo >= 8'd12);
    s = cs ? 8'd0 : s;
    m = cm ? 8'd0 : (cs ? m + 8'd1 : m);
    h = ch ? 8'd0 : (cm ? h + 8'd1 : h);
    dt = cd ? 8'd1 : (ch ? dt + 8'd1 : dt);
    mo = cmo ? 8'd1 : (cd ? mo + 8'd1 : mo);
    yr = cmo ? ((yr >= 8'd99) ? 8'd0 : yr + 8'd1) : yr;
    tmNxt.sec = toFmt(s, bin);
    tmNxt.min = toFmt(m, bin);
    h12 = (h % 8'd12 == 8'd0) ? 8'd12 : h % 8'd12;
    // 12h code keeps bit 7 free for the PM mark
    h12 = toFmt(h12, bin);
    if (ctlB_r[B_H24])
      tmNxt.hr = toFmt(h, bin);
    else
      tmNxt.hr = {h >= 8'd12, h12[6:0]};
    if (ch)
      tmNxt.day = (tm_r.day >= 8'd7) ? DAY_RST : tm_r.day + 8'd1;
    tmNxt.date = toFmt(dt, bin);
    tmNxt.mon = toFmt(mo, bin);
    tmNxt.year = toFmt(yr, bin);
  end

  assign almHit = almMatch(tm_r.hrAlm, tmNxt.hr) && almMatch(tm_r.minAlm, tmNxt.min)
    && almMatch(tm_r.secAlm, tmNxt.sec);

  // time and alarm bytes: counter update, then host write on top
  always_comb
  begin
    tmWr = tm_r;
    if (doUpdate)
      tmWr = tmNxt;
    // no lockout on writes
    // a write in the update cycle wins for its own byte only
    if (wrEn && idx <= IDX_LAST_TIME)
      tmWr[idx * 8 +: 8] = (idx == IDX_SEC) ? {1'b0, pwdata[6:0]} : pwdata[7:0];
  end

  // time and alarm register
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      tm_r <= '0;
      tm_r.day <= DAY_RST;
      tm_r.date <= DAY_RST;
      tm_r.mon <= DAY_RST;
    end
    else
      tm_r <= rtk_time_t'(tmWr);
  end

  // general purpose battery-backed bytes
  always_ff @(posedge clk_sys)
  begin
    if (wrEn && idx >= IDX_RAM_LO)
      ram_r[idx] <= pwdata[7:0];
  end

  // control registers A and B
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      div_r <= DIV_RST;
      rate_r <= RATE_RST;
      ctlB_r <= CTL_B_RST;
    end
    else if (oscSet)
      div_r <= DIV_RUN;
    else if (wrEn && idx == IDX_CTL_A)
    begin
      div_r <= pwdata[A_DIV_LSB +: 3];
      rate_r <= pwdata[3:0];
    end
    else if (wrEn && idx == IDX_CTL_B)
      ctlB_r <= pwdata[7:0];
  end

  // sticky event flags, set wins
  // the clearing read drops only flags captured in its read data, so a flag
  // raised between the setup and access edges is not lost
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      perFlag_r <= 1'b0;
      almFlag_r <= 1'b0;
      updFlag_r <= 1'b0;
    end
    else
    begin
      perFlag_r <= perTick || (perFlag_r && !(rdClr && prdata[F_PER]));
      almFlag_r <= (doUpdate && almHit) || (almFlag_r && !(rdClr && prdata[F_ALM]));
      updFlag_r <= doUpdate || (updFlag_r && !(rdClr && prdata[F_UPD]));
    end
  end

  assign flagsByte[F_IRQ] = (perFlag_r && ctlB_r[B_PIE]) || (almFlag_r && ctlB_r[B_AIE])
    || (updFlag_r && ctlB_r[B_UIE]);
  assign flagsByte[F_PER] = perFlag_r;
  assign flagsByte[F_ALM] = almFlag_r;
  assign flagsByte[F_UPD] = updFlag_r;
  assign flagsByte[3:0] = 4'h0;
  // open drain: the pin is only ever pulled low
  assign irqOut = 1'b0;
  assign irqOe = flagsByte[F_IRQ];

  // primary power sequencing
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pwr_r <= PWR_DOWN;
      recCnt_r <= 32'h00000000;
    end
    else
    begin
      case (pwr_r)
        PWR_DOWN:
          if (pwrS2_r && !pwrPrev_r)
          begin
            pwr_r <= running ? PWR_WAIT : PWR_UP;
            recCnt_r <= 32'h00000000;
          end
        PWR_WAIT:
          if (!pwrS2_r)
            pwr_r <= PWR_DOWN;
          else if (recCnt_r >= 32'(REC_CYC - 1))
            pwr_r <= PWR_UP;
          else
            recCnt_r <= recCnt_r + 32'h00000001;
        PWR_UP:
          if (!pwrS2_r)
            pwr_r <= PWR_DOWN;
        default:
          pwr_r <= PWR_DOWN;
      endcase
    end
  end

  // power state decode
  assign oscSet = (pwr_r == PWR_DOWN) && pwrS2_r && !pwrPrev_r && !oscOn;
  assign access = (pwr_r == PWR_UP);

  assign idx = paddr[8:2];
  assign mapped = (paddr[ADDR_W-1:9] == '0) && (paddr[1:0] == 2'b00);
  assign apbSetup = psel && !penable;
  assign apbDone = psel && penable;
  assign wrEn = apbDone && pwrite && pstrb[0] && mapped && access;
  assign rdClr = apbDone && !pwrite && mapped && access && (idx == IDX_FLAGS);
  assign pready = apbDone;
  assign pslverr = apbDone && !(mapped && access);
  assign tmBits = tm_r;
  assign ctlAByte = {pendFlag[0], div_r, rate_r};

  // read mux
  always_comb
  begin
    if (idx <= IDX_LAST_TIME)
      rdByte = tmBits[idx * 8 +: 8];
    else if (idx == IDX_CTL_A)
      rdByte = ctlAByte;
    else if (idx == IDX_CTL_B)
      rdByte = ctlB_r;
    else if (idx == IDX_FLAGS)
      rdByte = flagsByte;
    else if (idx == IDX_VALID)
      rdByte = VALID_VAL;
    else
      rdByte = ram_r[idx];
  end

  // read data captured in the setup cycle
  // capture at setup keeps prdata steady through the access cycle
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      prdata <= 32'h00000000;
    else if (apbSetup && !pwrite)
      prdata <= (mapped && access) ? {24'h000000, rdByte} : 32'h00000000;
  end

endmodule

// >>> verilog/rtk_pkg.sv
package rtk_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int BYTE_CNT = 128;

  // register indices, byte address is four times the index
  localparam logic [6:0] IDX_SEC = 7'h00;
  localparam logic [6:0] IDX_HR = 7'h04;
  localparam logic [6:0] IDX_LAST_TIME = 7'h09;
  localparam logic [6:0] IDX_CTL_A = 7'h0A;
  localparam logic [6:0] IDX_CTL_B = 7'h0B;
  localparam logic [6:0] IDX_FLAGS = 7'h0C;
  localparam logic [6:0] IDX_VALID = 7'h0D;
  localparam logic [6:0] IDX_RAM_LO = 7'h0E;

  // control A fields
  localparam int A_PEND_BIT = 7;
  localparam int A_DIV_LSB = 4;
  localparam logic [2:0] DIV_RUN = 3'b010;
  localparam logic [1:0] DIV_HOLD_HI = 2'b11;
  // control B fields
  localparam int B_FREEZE = 7;
  localparam int B_PIE = 6;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int B_FMT = 2;
  localparam int B_H24 = 1;
  // flag register fields
  localparam int F_IRQ = 7;
  localparam int F_PER = 6;
  localparam int F_ALM = 5;
  localparam int F_UPD = 4;
  localparam logic [7:0] VALID_VAL = 8'h80;

  // reset values
  localparam logic [2:0] DIV_RST = 3'b000;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [7:0] CTL_B_RST = 8'h02;
  localparam logic [7:0] DAY_RST = 8'h01;

  // timing
  localparam longint CLK_HZ = 125000000;
  localparam int XTAL_HZ = 32768;
  localparam logic [14:0] SEC_LAST = 15'h7FFF;
  localparam logic [14:0] HALF_SEC = 15'h4000;
  localparam int PEND_LEAD_US = 244;
  localparam int PEND_TICKS = (PEND_LEAD_US * XTAL_HZ + 999999) / 1000000;
  localparam longint REC_DELAY_MS = 200;
  localparam longint REC_DELAY_CYC = REC_DELAY_MS * CLK_HZ / 1000;

  // time, calendar and alarm bytes, byte 0 in the low bits
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] mon;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hrAlm;
    logic [7:0] hr;
    logic [7:0] minAlm;
    logic [7:0] min;
    logic [7:0] secAlm;
    logic [7:0] sec;
  } rtk_time_t;

  // primary power states
  typedef enum logic [2:0] {
    PWR_DOWN = 3'b001,
    PWR_WAIT = 3'b010,
    PWR_UP = 3'b100
  } rtk_pwr_t;

endpackage
